// ==== core/tx_req_map.svh ====
// field positions, encodings and reset values of the transmit request engine
`ifndef TX_REQ_MAP_SVH
`define TX_REQ_MAP_SVH
// confirm_class bit positions
`define CC_END 3
`define CC_INT 2
`define CC_FULL 1
`define CC_REPEAT 0
// request_class value for timed-token asynchronous traffic
`define RQ_ASYNC 4'h8
// request_outcome codes
`define OUT_OK 4'h1
`define OUT_CONSIST 4'h2
`define OUT_COUNT 4'h3
`define OUT_HALT 4'h4
`define OUT_PART 4'h5
// confirm_flags bits
`define CF_FINAL 0
`define CF_INTER 1
// reset and step values
`define TALLY_ZERO 8'h00
`define TALLY_ONE 8'h01
`define FIELD4_ZERO 4'h0
`define TAG_ZERO 6'h00
`define PTR_ZERO 28'h0000000
`endif

// ==== core/tx_req_pkg.sv ====
// types shared by the transmit request engine
package tx_req_pkg;
   // one request descriptor as taken from the request queue
   typedef struct packed {
      logic first;
      logic last;
      logic [5:0] request_tag;
      logic [3:0] confirm_class;
      logic [3:0] request_class;
      logic [7:0] frame_control_override;
      logic [27:0] descriptor_array_pointer;
      logic [7:0] frame_count;
   } req_desc_t;
   // how the transmitter behaves for the current object
   typedef struct packed {
      logic [3:0] tx_behaviour_class;
      logic async_timed;
      logic repeat_frame;
      logic override_en;
      logic [7:0] frame_control_override;
   } tx_behaviour_t;
   // one status entry for the status queue
   typedef struct packed {
      logic [3:0] request_outcome;
      logic [3:0] strip_attributes;
      logic [7:0] returned_frame_flags;
      logic [7:0] sent_frame_tally;
      logic [7:0] stripped_frame_tally;
      logic [5:0] request_tag;
      logic [7:0] frame_control_override;
      logic [7:0] confirm_flags;
   } status_entry_t;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_SEG = 3'b001,
      S_NEXT = 3'b010,
      S_DISCARD = 3'b011,
      S_TX = 3'b100
   } eng_state_t;
endpackage

// ==== core/seg_counter.sv ====
// counts frame-ending segment descriptors of one array and checks the total
`timescale 1ns/10ps
`include "tx_req_map.svh"
module seg_counter (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic clear_i,
   input wire logic seg_valid_i,
   input wire logic seg_last_i,
   input wire logic seg_end_i,
   input wire logic [7:0] frame_count_i,
   output logic done_o,
   output logic mismatch_o
);
   logic [7:0] count;
   logic [7:0] next_count;
   // segments with the last flag close one frame each
   assign next_count = count + ((seg_valid_i & seg_last_i) ? `TALLY_ONE : `TALLY_ZERO);
   assign done_o = seg_valid_i & seg_end_i;
   assign mismatch_o = done_o & (next_count != frame_count_i);
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) count <= `TALLY_ZERO;
      else if (ce_i) count <= clear_i ? `TALLY_ZERO : next_count;
   end
   a_count_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ce_i && clear_i |=> count == `TALLY_ZERO)
      else $error("segment count not cleared");
endmodule

// ==== core/status_builder.sv ====
// forms and registers one status entry per emit request
`timescale 1ns/10ps
`include "tx_req_map.svh"
module status_builder (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic emit_i,
   input wire logic [3:0] outcome_i,
   input wire logic [5:0] tag_i,
   input wire logic full_i,
   input wire logic final_i,
   input wire logic [7:0] sent_i,
   input wire logic [7:0] stripped_i,
   input wire logic strip_valid_i,
   input wire logic [3:0] strip_attr_i,
   input wire logic [7:0] strip_flags_i,
   input wire logic [7:0] strip_fc_i,
   output logic status_valid_o,
   output tx_req_pkg::status_entry_t status_o
);
   import tx_req_pkg::*;
   logic [3:0] attr;
   logic [7:0] flags;
   logic [7:0] fc;
   status_entry_t next_status;
   // strip-time fields only hold meaning under full confirmation
   assign next_status.request_outcome = outcome_i;
   assign next_status.strip_attributes = full_i ? attr : `FIELD4_ZERO;
   assign next_status.returned_frame_flags = full_i ? flags : `TALLY_ZERO;
   assign next_status.sent_frame_tally = sent_i;
   assign next_status.stripped_frame_tally = full_i ? stripped_i : `TALLY_ZERO;
   assign next_status.request_tag = tag_i;
   assign next_status.frame_control_override = full_i ? fc : `TALLY_ZERO;
   assign next_status.confirm_flags = {6'h00, ~final_i, final_i};
   // remember the last frame back from the ring
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         attr <= `FIELD4_ZERO;
         flags <= `TALLY_ZERO;
         fc <= `TALLY_ZERO;
      end else if (ce_i && strip_valid_i) begin
         attr <= strip_attr_i;
         flags <= strip_flags_i;
         fc <= strip_fc_i;
      end
   end
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         status_valid_o <= 1'b0;
         status_o <= '0;
      end else if (ce_i) begin
         status_valid_o <= emit_i;
         if (emit_i) status_o <= next_status;
      end
   end
   a_tag_copy: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ce_i && emit_i |=> status_valid_o && status_o.request_tag == $past(tag_i))
      else $error("status tag differs from object tag");
   a_tx_fields: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ce_i && emit_i && !full_i |=> status_o.stripped_frame_tally == `TALLY_ZERO)
      else $error("strip tally shown under transmit confirmation");
endmodule

// ==== core/tx_req_engine.sv ====
// transmit request descriptor engine for one transmit channel
`timescale 1ns/10ps
`include "tx_req_map.svh"
// Overview of operation
// - First descriptor's classes and override apply to the whole object, its tag to every status not formed in a take cycle.
// - Pointer and frame count of every descriptor are used.
// - Host tag is copied unchanged into every status entry.
// - Frame-ending segments are counted and compared with the frame count.
// - Confirm class: end, intermediate, full bits plus a repeat bit.
// - End and intermediate clear: status only on exceptions.
// - End, no full: one status per object at transmit time.
// - End with full: one status per object at strip time.
// - Intermediate with end set: extra status at each opportunity end with frames sent.
// - Intermediate tallies are cumulative for the object.
// - Request class picks token capture, sending mode and issued token.
// - Class 1000 means timed-token asynchronous sending.
// - Frame control override applies unless transparency is enabled.
// - First and last flags group descriptors into one object.
// - Pointer field addresses the segment descriptor array to fetch.
// - Transmit-time status: tag, sent tally, outcome valid only.
// - Strip-time status fills every field.
// - Bad returned status under full halts and drops the object.
// - First after first: consistency failure, discard until a last.
// - At most one object per opportunity on this channel.
module tx_req_engine (
   // clock, reset, enable
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // request queue
   input wire logic req_valid_i,
   input wire tx_req_pkg::req_desc_t req_i,
   output logic req_ready_o,
   // service opportunity
   input wire logic opp_start_i,
   input wire logic opp_end_i,
   // segment descriptor fetch
   output logic seg_fetch_o,
   output logic [27:0] seg_ptr_o,
   input wire logic seg_valid_i,
   input wire logic seg_last_i,
   input wire logic seg_end_i,
   // channel configuration
   input wire logic fc_transparent_i,
   input wire logic [7:0] expected_mask_i,
   input wire logic [7:0] expected_flags_i,
   // transmitter
   output logic tx_go_o,
   output tx_req_pkg::tx_behaviour_t tx_behaviour_o,
   output logic tx_halt_o,
   input wire logic tx_frame_sent_i,
   input wire logic strip_valid_i,
   input wire logic [3:0] strip_attr_i,
   input wire logic [7:0] strip_flags_i,
   input wire logic [7:0] strip_fc_i,
   // status queue
   output logic status_valid_o,
   output tx_req_pkg::status_entry_t status_o,
   output logic consist_err_o
);
   import tx_req_pkg::*;

   // ==========================================================
   // state and captured object attributes
   eng_state_t state;
   eng_state_t next_state;
   logic [5:0] tag;
   logic [3:0] cclass;
   logic [7:0] total;
   logic [7:0] sent;
   logic [7:0] stripped;
   logic sent_opp;
   logic got_last;
   logic opp_free;
   logic [7:0] desc_count;

   // ==========================================================
   // decode of handshakes and events
   logic take;
   logic take_first;
   logic take_cont;
   logic obj_live;
   logic endb;
   logic intb;
   logic full;
   logic seg_done;
   logic seg_mismatch;
   logic strip_bad;
   logic consist_err;
   logic count_err;
   logic tx_done;
   logic strip_done;
   logic obj_done;
   logic inter;
   logic abort;
   logic abort_last;
   logic emit;
   logic next_ready;
   logic [3:0] outcome;

   assign take = req_valid_i & req_ready_o;
   assign take_first = take & (state == S_IDLE) & req_i.first;
   assign take_cont = take & (state == S_NEXT) & ~req_i.first;
   assign obj_live = (state == S_SEG) | (state == S_NEXT) | (state == S_TX);
   assign endb = cclass[`CC_END];
   assign intb = cclass[`CC_INT];
   assign full = cclass[`CC_FULL];
   // under full confirmation, a returned frame outside the expected status aborts the object
   assign strip_bad = strip_valid_i & full & obj_live &
      (|((strip_flags_i ^ expected_flags_i) & expected_mask_i));
   // a middle or last with no opening first, or a first inside an object
   assign consist_err = take & (((state == S_IDLE) & ~req_i.first) |
      ((state == S_NEXT) & req_i.first));
   assign count_err = (state == S_SEG) & seg_mismatch;
   // completion compares registered tallies, so it lags the event one cycle
   assign tx_done = (state == S_TX) & ~full & (sent == total);
   assign strip_done = (state == S_TX) & full & (stripped == total);
   assign obj_done = tx_done | strip_done;
   assign inter = opp_end_i & obj_live & endb & intb & sent_opp & ~obj_done;
   assign abort = strip_bad | count_err | (consist_err & (state == S_NEXT));
   assign abort_last = (take & (state == S_NEXT)) ? req_i.last : got_last;
   // exceptions always report; end-of-object only with the end bit
   assign emit = consist_err | count_err | strip_bad | (obj_done & endb) | inter;
   assign outcome = strip_bad ? `OUT_HALT :
                    count_err ? `OUT_COUNT :
                    consist_err ? `OUT_CONSIST :
                    obj_done ? `OUT_OK : `OUT_PART;

   // ==========================================================
   // sequencing of one request object
   always_comb begin
      next_state = state;
      case (state)
         S_IDLE: begin
            if (take_first) next_state = S_SEG;
            else if (take && !req_i.last) next_state = S_DISCARD;
         end
         S_SEG: begin
            if (abort) next_state = abort_last ? S_IDLE : S_DISCARD;
            else if (seg_done) next_state = got_last ? S_TX : S_NEXT;
         end
         S_NEXT: begin
            if (abort) next_state = abort_last ? S_IDLE : S_DISCARD;
            else if (take_cont) next_state = S_SEG;
         end
         S_DISCARD: begin
            if (take && req_i.last) next_state = S_IDLE;
         end
         S_TX: begin
            if (strip_bad || obj_done) next_state = S_IDLE;
         end
         default: next_state = S_IDLE;
      endcase
   end

   // one object per opportunity: the idle queue opens only on a fresh one
   assign next_ready = ((next_state == S_IDLE) & opp_free & ~take_first &
      ~opp_end_i) | (next_state == S_NEXT) | (next_state == S_DISCARD) |
      ((next_state == S_IDLE) & opp_start_i);

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) state <= S_IDLE;
      else if (ce_i) state <= next_state;
   end

   // opportunity bookkeeping
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) opp_free <= 1'b0;
      else if (ce_i) begin
         if (opp_start_i) opp_free <= 1'b1;
         else if (take_first || opp_end_i) opp_free <= 1'b0;
      end
   end

   // ==========================================================
   // attributes latched from the first descriptor only
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tag <= `TAG_ZERO;
         cclass <= `FIELD4_ZERO;
         tx_behaviour_o <= '0;
      end else if (ce_i && take_first) begin
         tag <= req_i.request_tag;
         cclass <= req_i.confirm_class;
         tx_behaviour_o.tx_behaviour_class <= req_i.request_class;
         tx_behaviour_o.async_timed <= (req_i.request_class == `RQ_ASYNC);
         tx_behaviour_o.repeat_frame <= req_i.confirm_class[`CC_REPEAT];
         tx_behaviour_o.override_en <= ~fc_transparent_i;
         tx_behaviour_o.frame_control_override <= req_i.frame_control_override;
      end
   end

   // per-descriptor fields: pointer and frame count of every descriptor
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         seg_ptr_o <= `PTR_ZERO;
         desc_count <= `TALLY_ZERO;
         got_last <= 1'b0;
      end else if (ce_i && (take_first || take_cont)) begin
         seg_ptr_o <= req_i.descriptor_array_pointer;
         desc_count <= req_i.frame_count;
         got_last <= req_i.last;
      end
   end

   // ==========================================================
   // frame tallies; sent and stripped run across opportunities
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         total <= `TALLY_ZERO;
         sent <= `TALLY_ZERO;
         stripped <= `TALLY_ZERO;
      end else if (ce_i) begin
         if (take_first) begin
            total <= req_i.frame_count;
            sent <= `TALLY_ZERO;
            stripped <= `TALLY_ZERO;
         end else begin
            if (take_cont) total <= total + req_i.frame_count;
            if (tx_frame_sent_i && obj_live) sent <= sent + `TALLY_ONE;
            if (strip_valid_i && obj_live) stripped <= stripped + `TALLY_ONE;
         end
      end
   end

   // frames sent in the current opportunity; a new frame wins over the clear
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) sent_opp <= 1'b0;
      else if (ce_i) begin
         if (tx_frame_sent_i && obj_live) sent_opp <= 1'b1;
         else if (opp_end_i || take_first) sent_opp <= 1'b0;
      end
   end

   // ==========================================================
   // registered strobes toward fetch, transmitter and queue
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         req_ready_o <= 1'b0;
         seg_fetch_o <= 1'b0;
         tx_go_o <= 1'b0;
         tx_halt_o <= 1'b0;
         consist_err_o <= 1'b0;
      end else if (ce_i) begin
         req_ready_o <= next_ready;
         seg_fetch_o <= take_first | take_cont;
         tx_go_o <= take_first;
         tx_halt_o <= abort;
         consist_err_o <= consist_err;
      end
   end

   // ==========================================================
   // segment descriptor counting
   seg_counter u_seg_counter (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .clear_i(take_first | take_cont),
      .seg_valid_i(seg_valid_i & (state == S_SEG)),
      .seg_last_i(seg_last_i),
      .seg_end_i(seg_end_i),
      .frame_count_i(desc_count),
      .done_o(seg_done),
      .mismatch_o(seg_mismatch)
   );

   // status entry formation; tag is the taken descriptor's in a take cycle, else the object's
   status_builder u_status_builder (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .emit_i(emit),
      .outcome_i(outcome),
      .tag_i(take ? req_i.request_tag : tag),
      .full_i(full & obj_live),
      .final_i(~inter | obj_done),
      .sent_i(sent),
      .stripped_i(stripped),
      .strip_valid_i(strip_valid_i),
      .strip_attr_i(strip_attr_i),
      .strip_flags_i(strip_flags_i),
      .strip_fc_i(strip_fc_i),
      .status_valid_o(status_valid_o),
      .status_o(status_o)
   );

   // ==========================================================
   // checks
   a_one_object: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ce_i && take_first && !opp_start_i |=> !opp_free)
      else $error("second object allowed in one opportunity");
   a_attr_capture: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ce_i && take_first |=> tag == $past(req_i.request_tag) &&
      tx_go_o && tx_behaviour_o.override_en == !$past(fc_transparent_i))
      else $error("first descriptor attributes not captured");
   a_seg_pointer: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ce_i && (take_first || take_cont) |=> seg_fetch_o &&
      seg_ptr_o == $past(req_i.descriptor_array_pointer))
      else $error("segment array fetch missing or wrong");
   a_consist_drop: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ce_i && take && state == S_NEXT && req_i.first && !req_i.last
      |=> state == S_DISCARD ##0 consist_err_o)
      else $error("first after first not discarded");
   a_count_check: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ce_i && count_err && !strip_bad |=> status_valid_o &&
      status_o.request_outcome == `OUT_COUNT)
      else $error("frame count mismatch not reported");
   a_none_quiet: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ce_i && obj_done && !endb && !strip_bad |=> !status_valid_o)
      else $error("status produced without end confirmation");
   a_halt_strip: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ce_i && strip_bad |=> tx_halt_o && status_valid_o &&
      status_o.request_outcome == `OUT_HALT)
      else $error("bad returned frame did not halt");
   a_async_class: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ce_i && take_first && req_i.request_class == `RQ_ASYNC
      |=> tx_behaviour_o.async_timed)
      else $error("class 1000 not marked asynchronous");
   a_inter_tally: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ce_i && inter |=> status_valid_o && status_o.sent_frame_tally == $past(sent))
      else $error("intermediate tally not cumulative");
endmodule

// ==== testbench/seg_host_model.sv ====
// host memory model serving segment descriptor arrays
`timescale 1ns/10ps
module seg_host_model (
   // clock and fetch request
   input wire logic core_clk_i,
   input wire logic seg_fetch_i,
   input wire logic [7:0] frames_i,
   // segment stream
   output logic seg_valid_o,
   output logic seg_last_o,
   output logic seg_end_o
);
   // ==========
   // one frame-closing segment per frame
   // idle qualifiers toggle so a stale value is never trusted
   initial begin
      seg_valid_o = 1'b0;
      seg_last_o = 1'b0;
      seg_end_o = 1'b0;
      forever begin
         @(posedge core_clk_i);
         #1;
         seg_last_o = ~seg_last_o;
         seg_end_o = ~seg_end_o;
         if (seg_fetch_i === 1'b1) begin
            for (int i = 0; i < frames_i; i++) begin
               @(posedge core_clk_i);
               #1;
               seg_valid_o = 1'b1;
               seg_last_o = 1'b1;
               seg_end_o = (i == frames_i - 1);
               @(posedge core_clk_i);
               #1;
               seg_valid_o = 1'b0;
            end
         end
      end
   end
endmodule

// ==== testbench/tb_tx_req_engine.sv ====
// self-checking bench of the transmit request engine
`timescale 1ns/10ps
`include "tx_req_map.svh"
module tb_tx_req_engine;
   import tx_req_pkg::*;
   logic core_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic req_valid_i = 1'b0, opp_start_i = 1'b0, opp_end_i = 1'b0, fc_trans = 1'b0;
   logic sent = 1'b0, strip_v = 1'b0, ce = 1'b1;
   logic [7:0] strip_fl = 8'h00, nfr = 8'h01;
   req_desc_t req_i = '0;
   logic req_ready_o, seg_fetch_o, tx_go_o, tx_halt_o, status_valid_o, consist_err_o;
   logic seg_valid, seg_last, seg_end;
   logic [27:0] seg_ptr_o, ptr;
   tx_behaviour_t beh_o, beh;
   status_entry_t status_o, st;
   int nst = 0, nhalt = 0, ncon = 0, failures = 0, compares = 0;
   always #2 core_clk_i = ~core_clk_i;
   // ==========
   // design and host memory partner
   tx_req_engine tx_req_engine_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
      .ce_i(ce), .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
      .opp_start_i(opp_start_i), .opp_end_i(opp_end_i), .seg_fetch_o(seg_fetch_o),
      .seg_ptr_o(seg_ptr_o), .seg_valid_i(seg_valid), .seg_last_i(seg_last),
      .seg_end_i(seg_end), .fc_transparent_i(fc_trans), .expected_mask_i(8'hFF),
      .expected_flags_i(8'h24), .tx_go_o(tx_go_o), .tx_behaviour_o(beh_o),
      .tx_halt_o(tx_halt_o), .tx_frame_sent_i(sent), .strip_valid_i(strip_v),
      .strip_attr_i(4'h6), .strip_flags_i(strip_fl), .strip_fc_i(8'h5A),
      .status_valid_o(status_valid_o), .status_o(status_o), .consist_err_o(consist_err_o));
   seg_host_model seg_host_model_inst (.core_clk_i(core_clk_i), .seg_fetch_i(seg_fetch_o),
      .frames_i(nfr), .seg_valid_o(seg_valid), .seg_last_o(seg_last), .seg_end_o(seg_end));
   // capture one-cycle outputs in the cycle they stand
   always @(posedge core_clk_i) begin
      if (status_valid_o === 1'b1) begin
         st <= status_o;
         nst <= nst + 1;
      end
      if (tx_go_o === 1'b1) begin
         beh <= beh_o;
         ptr <= seg_ptr_o;
      end
      if (tx_halt_o === 1'b1) nhalt <= nhalt + 1;
      if (consist_err_o === 1'b1) ncon <= ncon + 1;
   end
   // ==========
   // shared tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   task automatic opp(input logic e);
      tick(1);
      opp_start_i = ~e;
      opp_end_i = e;
      tick(1);
      opp_start_i = 1'b0;
      opp_end_i = 1'b0;
   endtask
   // descriptor fields held until the edge that takes them
   task automatic send(input logic f, input logic l, input logic [5:0] tag,
         input logic [3:0] cc, input logic [7:0] cnt);
      int n;
      tick(1);
      req_i = '{f, l, tag, cc, `RQ_ASYNC, 8'hC3, 28'h0123ABC, cnt};
      req_valid_i = 1'b1;
      for (n = 0; n < 60 && req_ready_o !== 1'b1; n++) @(negedge core_clk_i);
      if (n == 60) failures++;
      tick(1);
      req_valid_i = 1'b0;
      tick(20);
   endtask
   task automatic frames(input int n);
      repeat (n) begin
         tick(1);
         sent = 1'b1;
         tick(1);
         sent = 1'b0;
      end
   endtask
   task automatic strip(input logic [7:0] fl);
      tick(1);
      strip_v = 1'b1;
      strip_fl = fl;
      tick(1);
      strip_v = 1'b0;
   endtask
   task automatic wait_st(input int k);
      for (int n = 0; n < 60 && nst < k; n++) tick(1);
      if (nst < k) failures++;
   endtask
   // ==========
   // scenarios
   task automatic s_tend();
      int k = nst;
      nfr = 8'h03;
      opp(1'b0);
      send(1'b1, 1'b1, 6'h2A, 4'h8, 8'h03);
      chk(beh.tx_behaviour_class, `RQ_ASYNC);
      chk(beh.async_timed, 1'b1);
      chk({beh.override_en, beh.frame_control_override}, 9'h1C3);
      chk(ptr, 28'h0123ABC);
      // a frame pulse while the enable is low must not be counted
      ce = 1'b0;
      frames(1);
      ce = 1'b1;
      frames(2);
      tick(3);
      chk(nst, k);
      frames(1);
      wait_st(k + 1);
      chk(st.request_outcome, `OUT_OK);
      chk(st.request_tag, 6'h2A);
      chk({st.sent_frame_tally, st.stripped_frame_tally}, 16'h0300);
      chk(st.confirm_flags[`CF_FINAL], 1'b1);
      nfr = 8'h01;
      opp(1'b0);
      send(1'b1, 1'b1, 6'h01, 4'h0, 8'h01);
      frames(1);
      tick(10);
      chk(nst, k + 1);
   endtask
   // two descriptors over two opportunities, later tag and classes ignored
   task automatic s_tint();
      int k = nst;
      nfr = 8'h02;
      opp(1'b0);
      send(1'b1, 1'b0, 6'h11, 4'hC, 8'h02);
      frames(2);
      opp(1'b1);
      wait_st(k + 1);
      chk({st.request_outcome, st.sent_frame_tally}, {`OUT_PART, 8'h02});
      chk(st.confirm_flags[`CF_INTER], 1'b1);
      opp(1'b0);
      send(1'b0, 1'b1, 6'h3F, 4'h0, 8'h02);
      frames(2);
      wait_st(k + 2);
      chk(st.sent_frame_tally, 8'h04);
      chk(st.request_tag, 6'h11);
   endtask
   task automatic s_full();
      int k = nst;
      nfr = 8'h01;
      opp(1'b0);
      send(1'b1, 1'b1, 6'h05, 4'hA, 8'h01);
      frames(1);
      strip(8'h24);
      wait_st(k + 1);
      chk({st.request_outcome, st.strip_attributes}, {`OUT_OK, 4'h6});
      chk({st.returned_frame_flags, st.stripped_frame_tally}, 16'h2401);
      chk(st.frame_control_override, 8'h5A);
      k = nhalt;
      nfr = 8'h02;
      opp(1'b0);
      send(1'b1, 1'b1, 6'h06, 4'hA, 8'h02);
      frames(2);
      strip(8'h00);
      wait_st(nst + 1);
      chk(st.request_outcome, `OUT_HALT);
      chk(nhalt, k + 1);
   endtask
   // error statuses arrive while send is still waiting, so counts are taken first
   task automatic s_errs();
      int kh = nhalt;
      int kc = ncon;
      int m = nst;
      fc_trans = 1'b1;
      nfr = 8'h03;
      opp(1'b0);
      send(1'b1, 1'b1, 6'h09, 4'h8, 8'h02);
      wait_st(m + 1);
      chk(st.request_outcome, `OUT_COUNT);
      chk({nhalt, beh.override_en}, {kh + 1, 1'b0});
      opp(1'b0);
      send(1'b0, 1'b1, 6'h07, 4'h8, 8'h01);
      wait_st(m + 2);
      chk(st.request_outcome, `OUT_CONSIST);
      chk(ncon, kc + 1);
      // a first inside an open object halts it; the closing last is dropped
      nfr = 8'h01;
      send(1'b1, 1'b0, 6'h0B, 4'h8, 8'h01);
      send(1'b1, 1'b0, 6'h0C, 4'h8, 8'h01);
      send(1'b0, 1'b1, 6'h0D, 4'h8, 8'h01);
      wait_st(m + 3);
      chk(st.request_outcome, `OUT_CONSIST);
      chk(ncon, kc + 2);
      chk(nhalt, kh + 2);
      chk(nst, m + 3);
   endtask
   task automatic summarize();
      $display("failures=%0d compares=%0d", failures, compares);
      if (failures == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ==========
   // main sequence and watchdog
   initial begin
      tick(10);
      rst_n_i = 1'b1;
      s_tend();
      s_tint();
      s_full();
      s_errs();
      summarize();
   end
   initial begin
      #100000;
      failures++;
      summarize();
   end
endmodule
